// ### rtl/eci_pkg.sv
// Shared constants for the encoder channel input image.
// Assumes one system clock; all users write eci_pkg::name.
package eci_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int CNT_W = 32;
  localparam int TS_W = 64;
  localparam int DUTY_W = 16;
  localparam int CMD_W = 16;
  localparam int SYNC_STAGES = 3;

  // ------------------------------------------------------------
  // Pin positions in the synchronised pin vector
  // ------------------------------------------------------------
  localparam int PIN_N = 6;
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_GATE = 3;
  localparam int PIN_CAP = 4;
  localparam int PIN_ALARM = 5;

  // ------------------------------------------------------------
  // Reset values and fixed image contents
  // ------------------------------------------------------------
  localparam logic [7:0] ENTRY_COUNT_RST = 8'h25;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0;
  localparam logic [TS_W-1:0] TS_RST = 64'h0;
  localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0;

  // ------------------------------------------------------------
  // Clear commands; the channel index is added to the base code
  // ------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_CLR_MIN_BASE = 16'h9130;
  localparam logic [CMD_W-1:0] CMD_CLR_MAX_BASE = 16'h9140;

  // ------------------------------------------------------------
  // Release points of the limit flags, in thirds of the range
  // ------------------------------------------------------------
  localparam logic [1:0] UNDER_CLR_THIRDS = 2'h2;
  localparam logic [1:0] OVER_CLR_THIRDS = 2'h1;

  typedef logic [CNT_W-1:0] eci_count_t;

endpackage

// ### rtl/eci_pin_if.sv
// Carries synchronised pin levels and their edge pulses.
// Assumes the producer and consumer share clk_sys.
`timescale 1ns/1ps
interface eci_pin_if #(parameter int W = 6);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ### rtl/eci_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes asynchronous pins and a free-running clk_sys.
`timescale 1ns/1ps
module eci_pin_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw pins
  input wire logic [W-1:0] pin_raw,
  // Synchronised view
  eci_pin_if.src sync
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;
  logic [W-1:0] stage3_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] rise_ff;
  logic [W-1:0] fall_ff;
  logic [W-1:0] nxt_level;
  wire [W-1:0] agree = ~(stage2_ff ^ stage3_ff);

  // A change is accepted only once the last two stages agree.
  assign nxt_level = (agree & stage3_ff) | (~agree & level_ff);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      level_ff <= '0;
      rise_ff <= '0;
      fall_ff <= '0;
    end else begin
      stage1_ff <= pin_raw;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
      rise_ff <= nxt_level & ~level_ff;
      fall_ff <= ~nxt_level & level_ff;
    end
  end

  assign sync.level = level_ff;
  assign sync.rise = rise_ff;
  assign sync.fall = fall_ff;

endmodule // eci_pin_sync

// ### rtl/eci_input_image.sv
// Per-channel input image of an incremental encoder interface.
// Assumes the counter core runs on clk_sys and delivers its results
// as levels and one-cycle pulses; pins arrive asynchronously.
//
// Functional notes
// - Zero-pulse capture sets its valid flag once the count is captured.
// - External capture sets its valid flag once the count is captured.
// - Preset-done flag rises after the counter was loaded.
// - Underflow flag set below lower limit, cleared below two thirds.
// - Overflow flag set above upper limit, cleared below one third.
// - Alarm input level shown as one status bit.
// - Open-circuit flag raised by enabled broken-wire detection.
// - Stall flag marks the interpolated count part invalid.
// - Levels of tracks A, B, C and gate shown as status bits.
// - Capture input level shown only in legacy mode.
// - Legacy with time sync: sync without new data flags error.
// - Legacy mode drives the data-invalid bit, one meaning invalid.
// - Legacy mode inverts the toggle bit on each image update.
// - Frequency and period given as scaled 32-bit values.
// - Timestamp of the latest count change is held.
// - Timestamp of the latest zero-pulse rising edge is held.
// - Timestamp of the latest qualified capture edge is held.
// - Gate as second capture stores count and edge timestamp.
// - Duty cycle given as a 16-bit ratio.
// - Smallest and largest duty cycles tracked, 16 bits each.
// - Clear commands zero the duty minimum or maximum record.
// - Channel index selects which clear commands this image obeys.
`timescale 1ns/1ps
module eci_input_image #(
  parameter logic CHAN_IDX = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Encoder pins
  input wire logic pin_track_a,
  input wire logic pin_track_b,
  input wire logic pin_track_c,
  input wire logic pin_gate,
  input wire logic pin_capture,
  input wire logic pin_alarm,
  // Counter core results
  input wire logic [31:0] count_value,
  input wire logic [31:0] limit_low,
  input wire logic [31:0] limit_high,
  input wire logic preset_evt,
  input wire logic underflow_evt,
  input wire logic overflow_evt,
  input wire logic [31:0] freq_value,
  input wire logic [31:0] period_value,
  input wire logic [15:0] duty_value,
  input wire logic duty_new,
  input wire logic stall_in,
  input wire logic [2:0] wire_fault,
  input wire logic [2:0] wire_check_en,
  input wire logic [63:0] time_now,
  // Control and cycle timing
  input wire logic cycle_tick,
  input wire logic new_data,
  input wire logic sync_evt,
  input wire logic legacy_mode,
  input wire logic distributed_time_sync_mode,
  input wire logic data_invalid,
  input wire logic preset_req,
  input wire logic en_zero_capture,
  input wire logic en_capture_pos,
  input wire logic en_capture_neg,
  input wire logic gate_as_capture,
  input wire logic en_capture2_pos,
  input wire logic en_capture2_neg,
  // Commands
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  // Input image
  output logic [7:0] input_image_entry_count,
  output logic zero_pulse_capture_valid,
  output logic external_capture_valid,
  output logic preset_done,
  output logic count_underflow_flag,
  output logic count_overflow_flag,
  output logic alarm_input_level,
  output logic broken_wire_flag,
  output logic interpolation_stall_flag,
  output logic track_a_level,
  output logic track_b_level,
  output logic track_c_level,
  output logic gate_input_level,
  output logic capture_input_level,
  output logic sync_miss_flag,
  output logic tx_data_invalid,
  output logic tx_data_toggle,
  output logic [31:0] position_count,
  output logic [31:0] captured_count,
  output logic [31:0] frequency_measure,
  output logic [31:0] period_measure,
  output logic [63:0] count_change_time,
  output logic [63:0] zero_pulse_time,
  output logic [63:0] capture_edge_time,
  output logic [63:0] second_capture_time,
  output logic [31:0] second_captured_count,
  output logic [15:0] pulse_ratio,
  output logic [15:0] pulse_ratio_lowest,
  output logic [15:0] pulse_ratio_highest
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  eci_pin_if #(.W(eci_pkg::PIN_N)) pins ();
  eci_pin_sync #(.W(eci_pkg::PIN_N)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_raw({pin_alarm, pin_capture, pin_gate, pin_track_c, pin_track_b, pin_track_a}),
    .sync(pins)
  );

  // Point inside the counting range, in thirds from the lower limit.
  // The span is widened so the product cannot wrap; hi >= lo assumed.
  function automatic eci_pkg::eci_count_t range_point(
    input eci_pkg::eci_count_t lo,
    input eci_pkg::eci_count_t hi,
    input logic [1:0] thirds
  );
    logic [33:0] span;
    span = 34'(({2'b00, hi} - {2'b00, lo}) * {32'h0, thirds});
    return lo + 32'(span / 34'd3);
  endfunction

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  wire zp_hit = pins.rise[eci_pkg::PIN_C] & en_zero_capture;
  wire cap_hit = (pins.rise[eci_pkg::PIN_CAP] & en_capture_pos) |
                 (pins.fall[eci_pkg::PIN_CAP] & en_capture_neg);
  wire cap2_hit = gate_as_capture & ((pins.rise[eci_pkg::PIN_GATE] & en_capture2_pos) |
                  (pins.fall[eci_pkg::PIN_GATE] & en_capture2_neg));
  wire [31:0] under_clr_point = range_point(limit_low, limit_high, eci_pkg::UNDER_CLR_THIRDS);
  wire [31:0] over_clr_point = range_point(limit_low, limit_high, eci_pkg::OVER_CLR_THIRDS);
  wire under_release = count_value < under_clr_point;
  wire over_release = count_value < over_clr_point;
  wire clr_min = cmd_valid && (cmd_code == (eci_pkg::CMD_CLR_MIN_BASE |
                                            {15'h0, CHAN_IDX}));
  wire clr_max = cmd_valid && (cmd_code == (eci_pkg::CMD_CLR_MAX_BASE |
                                            {15'h0, CHAN_IDX}));
  wire legacy_sync = legacy_mode & distributed_time_sync_mode;

  // ------------------------------------------------------------
  // Live state, collected between image updates
  // ------------------------------------------------------------
  logic zp_valid_ff;
  logic cap_valid_ff;
  logic preset_done_ff;
  logic underflow_ff;
  logic overflow_ff;
  logic data_seen_ff;
  logic sync_err_ff;
  logic min_empty_ff;
  logic [31:0] count_prev_ff;
  logic [31:0] cap_count_ff;
  logic [31:0] cap2_count_ff;
  logic [63:0] change_time_ff;
  logic [63:0] zp_time_ff;
  logic [63:0] cap_time_ff;
  logic [63:0] cap2_time_ff;
  logic [15:0] duty_min_ff;
  logic [15:0] duty_max_ff;

  // Capture and preset flags hold while their enable or request stays up; a new event in the same
  // cycle as the release wins, so no capture is lost.
  wire nxt_zp_valid = zp_hit | (zp_valid_ff & en_zero_capture);
  wire nxt_cap_valid = cap_hit | (cap_valid_ff & (en_capture_pos | en_capture_neg));
  wire nxt_preset_done = preset_evt | (preset_done_ff & preset_req);
  wire nxt_underflow = underflow_evt | (underflow_ff & ~under_release);
  wire nxt_overflow = overflow_evt | (overflow_ff & ~over_release);
  wire nxt_data_seen = new_data | (data_seen_ff & ~sync_evt);
  wire count_moved = count_value != count_prev_ff;
  wire min_take = duty_new & (min_empty_ff | (duty_value < duty_min_ff));
  wire max_take = duty_new & (duty_value > duty_max_ff);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zp_valid_ff <= eci_pkg::FLAG_RST;
      cap_valid_ff <= eci_pkg::FLAG_RST;
      preset_done_ff <= eci_pkg::FLAG_RST;
      underflow_ff <= eci_pkg::FLAG_RST;
      overflow_ff <= eci_pkg::FLAG_RST;
      data_seen_ff <= eci_pkg::FLAG_RST;
      sync_err_ff <= eci_pkg::FLAG_RST;
      min_empty_ff <= 1'b1;
      count_prev_ff <= eci_pkg::CNT_RST;
      cap_count_ff <= eci_pkg::CNT_RST;
      cap2_count_ff <= eci_pkg::CNT_RST;
      change_time_ff <= eci_pkg::TS_RST;
      zp_time_ff <= eci_pkg::TS_RST;
      cap_time_ff <= eci_pkg::TS_RST;
      cap2_time_ff <= eci_pkg::TS_RST;
    end else begin
      zp_valid_ff <= nxt_zp_valid;
      cap_valid_ff <= nxt_cap_valid;
      preset_done_ff <= nxt_preset_done;
      underflow_ff <= nxt_underflow;
      overflow_ff <= nxt_overflow;
      data_seen_ff <= nxt_data_seen;
      count_prev_ff <= count_value;
      if (sync_evt) begin
        sync_err_ff <= ~(data_seen_ff | new_data);
      end
      if (count_moved) begin
        change_time_ff <= time_now;
      end
      if (pins.rise[eci_pkg::PIN_C]) begin
        zp_time_ff <= time_now;
      end
      if (zp_hit) begin
        cap_count_ff <= count_value;
      end else if (cap_hit) begin
        cap_count_ff <= count_value;
      end
      if (cap_hit) begin
        cap_time_ff <= time_now;
      end
      if (cap2_hit) begin
        cap2_count_ff <= count_value;
        cap2_time_ff <= time_now;
      end
      if (clr_min) begin
        min_empty_ff <= 1'b1;
      end else if (min_take) begin
        min_empty_ff <= 1'b0;
      end
    end
  end

  // An explicit clear wins over a sample taken in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_min_ff <= eci_pkg::DUTY_RST;
      duty_max_ff <= eci_pkg::DUTY_RST;
    end else begin
      if (clr_min) begin
        duty_min_ff <= eci_pkg::DUTY_RST;
      end else if (min_take) begin
        duty_min_ff <= duty_value;
      end
      if (clr_max) begin
        duty_max_ff <= eci_pkg::DUTY_RST;
      end else if (max_take) begin
        duty_max_ff <= duty_value;
      end
    end
  end

  // ------------------------------------------------------------
  // Image update, coherent once per process data cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      input_image_entry_count <= eci_pkg::ENTRY_COUNT_RST;
      zero_pulse_capture_valid <= eci_pkg::FLAG_RST;
      external_capture_valid <= eci_pkg::FLAG_RST;
      preset_done <= eci_pkg::FLAG_RST;
      count_underflow_flag <= eci_pkg::FLAG_RST;
      count_overflow_flag <= eci_pkg::FLAG_RST;
      alarm_input_level <= eci_pkg::FLAG_RST;
      broken_wire_flag <= eci_pkg::FLAG_RST;
      interpolation_stall_flag <= eci_pkg::FLAG_RST;
      track_a_level <= eci_pkg::FLAG_RST;
      track_b_level <= eci_pkg::FLAG_RST;
      track_c_level <= eci_pkg::FLAG_RST;
      gate_input_level <= eci_pkg::FLAG_RST;
      capture_input_level <= eci_pkg::FLAG_RST;
      sync_miss_flag <= eci_pkg::FLAG_RST;
      tx_data_invalid <= eci_pkg::FLAG_RST;
      tx_data_toggle <= eci_pkg::FLAG_RST;
      position_count <= eci_pkg::CNT_RST;
      captured_count <= eci_pkg::CNT_RST;
      frequency_measure <= eci_pkg::CNT_RST;
      period_measure <= eci_pkg::CNT_RST;
      count_change_time <= eci_pkg::TS_RST;
      zero_pulse_time <= eci_pkg::TS_RST;
      capture_edge_time <= eci_pkg::TS_RST;
      second_capture_time <= eci_pkg::TS_RST;
      second_captured_count <= eci_pkg::CNT_RST;
      pulse_ratio <= eci_pkg::DUTY_RST;
      pulse_ratio_lowest <= eci_pkg::DUTY_RST;
      pulse_ratio_highest <= eci_pkg::DUTY_RST;
    end else if (cycle_tick) begin
      zero_pulse_capture_valid <= zp_valid_ff;
      external_capture_valid <= cap_valid_ff;
      preset_done <= preset_done_ff;
      count_underflow_flag <= underflow_ff;
      count_overflow_flag <= overflow_ff;
      alarm_input_level <= pins.level[eci_pkg::PIN_ALARM];
      broken_wire_flag <= |(wire_fault & wire_check_en);
      interpolation_stall_flag <= stall_in;
      track_a_level <= pins.level[eci_pkg::PIN_A];
      track_b_level <= pins.level[eci_pkg::PIN_B];
      track_c_level <= pins.level[eci_pkg::PIN_C];
      gate_input_level <= pins.level[eci_pkg::PIN_GATE];
      capture_input_level <= legacy_mode & pins.level[eci_pkg::PIN_CAP];
      sync_miss_flag <= legacy_sync & sync_err_ff;
      tx_data_invalid <= legacy_mode & data_invalid;
      tx_data_toggle <= tx_data_toggle ^ legacy_mode;
      position_count <= count_value;
      captured_count <= cap_count_ff;
      frequency_measure <= freq_value;
      period_measure <= period_value;
      count_change_time <= change_time_ff;
      zero_pulse_time <= zp_time_ff;
      capture_edge_time <= cap_time_ff;
      second_capture_time <= cap2_time_ff;
      second_captured_count <= cap2_count_ff;
      pulse_ratio <= duty_value;
      pulse_ratio_lowest <= duty_min_ff;
      pulse_ratio_highest <= duty_max_ff;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_zero_capture:
  assert property (zp_hit ##1 cycle_tick |=> zero_pulse_capture_valid &&
                   captured_count == $past(count_value, 2))
    else $error("zero-pulse capture not shown");
  chk_ext_capture_flag:
  assert property (cap_hit && !zp_hit |=> cap_valid_ff && cap_count_ff == $past(count_value))
    else $error("external capture not recorded");
  chk_preset_hold:
  assert property (preset_evt ##1 (preset_req && !cycle_tick) [*2] |-> preset_done_ff)
    else $error("preset done lost while request held");
  chk_underflow_release:
  assert property (underflow_ff && !underflow_evt && under_release |=> !underflow_ff)
    else $error("underflow flag not released");
  chk_overflow_set:
  assert property (overflow_evt ##1 cycle_tick |=> count_overflow_flag)
    else $error("overflow flag not shown");
  chk_wire_masked:
  assert property (cycle_tick && (wire_fault & wire_check_en) == 3'h0 |=> !broken_wire_flag)
    else $error("masked wire fault reported");
  chk_capture_level_mode:
  assert property (cycle_tick && !legacy_mode |=> !capture_input_level)
    else $error("capture level shown outside legacy mode");
  chk_sync_miss:
  assert property (sync_evt && !new_data && !data_seen_ff ##1 (cycle_tick && legacy_sync
                   && !sync_evt) |=> sync_miss_flag)
    else $error("sync miss not flagged");
  chk_toggle_flip:
  assert property (cycle_tick && legacy_mode |=> tx_data_toggle != $past(tx_data_toggle))
    else $error("toggle bit did not invert");
  chk_stable_between:
  assert property (!cycle_tick |=> $stable(position_count) && $stable(pulse_ratio))
    else $error("image changed outside an update");
  chk_duty_clear:
  assert property (clr_min ##1 cycle_tick |=> pulse_ratio_lowest == 16'h0)
    else $error("duty minimum not cleared");
  chk_duty_order:
  assert property (duty_new && !clr_max |=> duty_max_ff >= $past(duty_value))
    else $error("duty maximum below a sample");

  cov_zero_capture: cover property (zp_hit ##[1:20] cycle_tick);
  cov_second_capture: cover property (cap2_hit ##[1:20] cycle_tick);
  cov_sync_miss: cover property (legacy_sync && sync_evt && !data_seen_ff && !new_data);
  cov_overflow_release: cover property (overflow_ff ##1 !overflow_ff);

endmodule // eci_input_image

// ### test/eci_enc_model.sv
// Encoder partner: quadrature tracks, zero pulse, gate, capture and alarm pins.
// Assumes the bench asks for steps and levels in step with clk_sys.
`timescale 1ns/1ps
module eci_enc_model (
  // Clock
  input wire logic clk_sys,
  // Bench requests
  input wire logic enc_step,
  input wire logic enc_dir,
  input wire logic enc_zero,
  input wire logic enc_gate,
  input wire logic enc_cap,
  input wire logic enc_alarm,
  // Encoder pins
  output logic pin_track_a,
  output logic pin_track_b,
  output logic pin_track_c,
  output logic pin_gate,
  output logic pin_capture,
  output logic pin_alarm
);
  logic [1:0] phase_ff = 2'h0;
  // Gray order: only one track moves per step, as a real encoder does.
  always @(posedge clk_sys) begin
    if (enc_step)
      phase_ff <= enc_dir ? phase_ff + 2'h1 : phase_ff - 2'h1;
  end
  assign pin_track_a = phase_ff[1];
  assign pin_track_b = phase_ff[1] ^ phase_ff[0];
  assign pin_track_c = enc_zero;
  assign pin_gate = enc_gate;
  assign pin_capture = enc_cap;
  assign pin_alarm = enc_alarm;
endmodule // eci_enc_model

// ### test/eci_input_image_tb.sv
// Self-checking bench for the encoder channel input image, channel zero.
// Assumes the partner model drives the pins and the bench plays the counter core.
`timescale 1ns/1ps
module eci_input_image_tb;
  logic clk_sys, rst_n, pin_track_a, pin_track_b, pin_track_c, pin_gate, pin_capture, pin_alarm;
  logic [31:0] count_value, limit_low, limit_high, freq_value, period_value;
  logic preset_evt, underflow_evt, overflow_evt, duty_new, stall_in, cycle_tick, new_data;
  logic sync_evt, legacy_mode, distributed_time_sync_mode, data_invalid, preset_req;
  logic en_zero_capture, en_capture_pos, en_capture_neg, gate_as_capture, en_capture2_pos;
  logic en_capture2_neg, cmd_valid, tgl;
  logic [15:0] duty_value, cmd_code, lo_exp, hi_exp;
  logic [2:0] wire_fault, wire_check_en;
  logic [63:0] time_now, t_mark, t_chg;
  logic [7:0] input_image_entry_count;
  logic zero_pulse_capture_valid, external_capture_valid, preset_done, count_underflow_flag;
  logic count_overflow_flag, alarm_input_level, broken_wire_flag, interpolation_stall_flag;
  logic track_a_level, track_b_level, track_c_level, gate_input_level, capture_input_level;
  logic sync_miss_flag, tx_data_invalid, tx_data_toggle;
  logic [31:0] position_count, captured_count, frequency_measure, period_measure;
  logic [31:0] second_captured_count;
  logic [63:0] count_change_time, zero_pulse_time, capture_edge_time, second_capture_time;
  logic [15:0] pulse_ratio, pulse_ratio_lowest, pulse_ratio_highest;
  logic enc_step, enc_dir, enc_zero, enc_gate, enc_cap, enc_alarm;
  int failures, compares;

  eci_input_image #(.CHAN_IDX(1'b0)) u_eci_input_image (.*);
  eci_enc_model u_eci_enc_model (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) time_now <= rst_n ? time_now + 64'h1 : 64'h0;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rel_pt(input logic [31:0] lo, hi, input int th);
    return lo + (hi - lo) * th / 3;
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Outputs move only on the tick edge, so sample just after it.
  task automatic tick_now;
    cycle_tick <= 1'b1;
    @(posedge clk_sys);
    cycle_tick <= 1'b0;
    #1;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    tick_now;
  endtask
  task automatic send_cmd(input logic [15:0] code);
    @(posedge clk_sys);
    cmd_code <= code;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    tick_now;
  endtask
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    stop_test;
  end

  initial begin
    void'($urandom(14088));
    {rst_n, cycle_tick, new_data, sync_evt, cmd_valid, duty_new, preset_evt} = '0;
    {underflow_evt, overflow_evt, stall_in, legacy_mode, distributed_time_sync_mode} = '0;
    {data_invalid, preset_req, en_zero_capture, en_capture_pos, en_capture_neg} = '0;
    {gate_as_capture, en_capture2_pos, en_capture2_neg, wire_fault, wire_check_en} = '0;
    {enc_step, enc_dir, enc_zero, enc_gate, enc_cap, enc_alarm, cmd_code, duty_value} = '0;
    {count_value, freq_value, period_value} = '0;
    limit_low = 32'h100;
    limit_high = 32'h400;
    repeat (10) @(posedge clk_sys);
    chk("entry count", 64'h25, input_image_entry_count);
    chk("ratio max", 64'h0, pulse_ratio_highest);
    rst_n <= 1'b1;
    repeat (6) begin
      @(posedge clk_sys);
      {enc_dir, enc_zero, enc_gate, enc_cap, enc_alarm, legacy_mode} <= 6'($urandom);
      {stall_in, data_invalid, wire_fault, wire_check_en} <= 8'($urandom);
      count_value <= $urandom;
      freq_value <= $urandom;
      period_value <= $urandom;
      enc_step <= 1'b1;
      @(posedge clk_sys);
      enc_step <= 1'b0;
      repeat (8) @(posedge clk_sys);
      tick;
      chk("track a", pin_track_a, track_a_level);
      chk("track b", pin_track_b, track_b_level);
      chk("track c", pin_track_c, track_c_level);
      chk("gate", pin_gate, gate_input_level);
      chk("alarm", pin_alarm, alarm_input_level);
      chk("cap level", legacy_mode & pin_capture, capture_input_level);
      chk("stall", stall_in, interpolation_stall_flag);
      chk("open", |(wire_fault & wire_check_en), broken_wire_flag);
      chk("invalid", legacy_mode & data_invalid, tx_data_invalid);
      chk("count", count_value, position_count);
      chk("freq", freq_value, frequency_measure);
      chk("period", period_value, period_measure);
    end
    $display("test levels done");
    @(posedge clk_sys);
    {enc_zero, enc_cap, enc_gate, en_zero_capture, en_capture_neg} <= 5'h0b;
    {gate_as_capture, en_capture2_pos, preset_evt, preset_req} <= 4'hf;
    count_value <= 32'h1234_5678;
    #1 t_chg = time_now;
    @(posedge clk_sys);
    preset_evt <= 1'b0;
    repeat (7) @(posedge clk_sys);
    {enc_zero, enc_gate} <= 2'h3;
    #1 t_mark = time_now;
    @(posedge clk_sys);
    enc_cap <= 1'b0;
    repeat (4) @(posedge clk_sys);
    tick_now;
    tick;
    chk("zero valid", 64'h1, zero_pulse_capture_valid);
    chk("ext valid", 64'h1, external_capture_valid);
    chk("captured", 64'h1234_5678, captured_count);
    chk("preset", 64'h1, preset_done);
    chk("count time", t_chg, count_change_time);
    chk("zero time", t_mark + 64'h4, zero_pulse_time);
    chk("cap time", t_mark + 64'h5, capture_edge_time);
    chk("count 2", 64'h1234_5678, second_captured_count);
    chk("time 2", t_mark + 64'h4, second_capture_time);
    $display("test capture done");
    @(posedge clk_sys);
    {underflow_evt, overflow_evt, preset_evt, preset_req} <= 4'hf;
    count_value <= rel_pt(limit_low, limit_high, 2);
    @(posedge clk_sys);
    {underflow_evt, overflow_evt, preset_evt} <= 3'h0;
    tick_now;
    chk("preset", 64'h1, preset_done);
    chk("under", 64'h1, count_underflow_flag);
    chk("over", 64'h1, count_overflow_flag);
    @(posedge clk_sys);
    count_value <= rel_pt(limit_low, limit_high, 2) - 32'h1;
    tick;
    chk("under", 64'h0, count_underflow_flag);
    chk("over", 64'h1, count_overflow_flag);
    @(posedge clk_sys);
    count_value <= rel_pt(limit_low, limit_high, 1) - 32'h1;
    tick;
    chk("over", 64'h0, count_overflow_flag);
    $display("test limits done");
    @(posedge clk_sys);
    {legacy_mode, distributed_time_sync_mode, sync_evt} <= 3'h7;
    @(posedge clk_sys);
    sync_evt <= 1'b0;
    repeat (3) @(posedge clk_sys);
    sync_evt <= 1'b1;
    @(posedge clk_sys);
    sync_evt <= 1'b0;
    tick_now;
    chk("sync miss", 64'h1, sync_miss_flag);
    tgl = tx_data_toggle;
    tick;
    chk("toggle", !tgl, tx_data_toggle);
    @(posedge clk_sys);
    new_data <= 1'b1;
    @(posedge clk_sys);
    {new_data, sync_evt} <= 2'h1;
    @(posedge clk_sys);
    sync_evt <= 1'b0;
    tick;
    chk("sync ok", 64'h0, sync_miss_flag);
    $display("test legacy done");
    lo_exp = 16'hffff;
    hi_exp = 16'h0;
    repeat (6) begin
      @(posedge clk_sys);
      duty_value <= 16'($urandom);
      duty_new <= 1'b1;
      @(posedge clk_sys);
      duty_new <= 1'b0;
      lo_exp = (duty_value < lo_exp) ? duty_value : lo_exp;
      hi_exp = (duty_value > hi_exp) ? duty_value : hi_exp;
    end
    tick;
    chk("duty", duty_value, pulse_ratio);
    chk("duty min", lo_exp, pulse_ratio_lowest);
    chk("duty max", hi_exp, pulse_ratio_highest);
    send_cmd(16'h9131);
    chk("min kept", lo_exp, pulse_ratio_lowest);
    send_cmd(16'h9141);
    chk("max kept", hi_exp, pulse_ratio_highest);
    send_cmd(16'h9130);
    chk("min clear", 64'h0, pulse_ratio_lowest);
    send_cmd(16'h9140);
    chk("max clear", 64'h0, pulse_ratio_highest);
    chk("entry count", 64'h25, input_image_entry_count);
    $display("test duty done");
    stop_test;
  end
endmodule // eci_input_image_tb
